// *** src/tbd_pkg.sv ***
// shared constants for the touch button decision logic
package tbd_pkg;
  // structure
  localparam int NUM_BTN = 8;
  localparam int TICK_W = 16;
  localparam int LVL_W = 18;
  localparam int SEC_CNT_W = 25;
  // register addresses
  localparam logic [7:0] ADDR_CFG = 8'h21;
  localparam logic [7:0] ADDR_AVG = 8'h22;
  localparam logic [7:0] ADDR_NEG_THR = 8'h23;
  localparam logic [7:0] ADDR_NEG_CNT = 8'h24;
  localparam logic [7:0] ADDR_HYST = 8'h25;
  localparam logic [7:0] ADDR_STUCK = 8'h26;
  // reset values
  localparam logic [7:0] CFG_RESET = 8'h30;
  localparam logic [7:0] AVG_RESET = 8'h50;
  localparam logic [7:0] NEG_THR_RESET = 8'h50;
  localparam logic [7:0] NEG_CNT_RESET = 8'h01;
  localparam logic [7:0] HYST_RESET = 8'h0a;
  localparam logic [7:0] STUCK_RESET = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;
  // button_config field positions
  localparam int CFG_MODE_LSB = 6;
  localparam int CFG_IRQ_LSB = 4;
  localparam int CFG_REL_LSB = 2;
  localparam int CFG_TCH_LSB = 0;
  // reporting modes
  localparam logic [1:0] MODE_MULTI = 2'h0;
  localparam logic [1:0] MODE_FIRST = 2'h1;
  // bits inside the interrupt field
  localparam int IRQ_ON_TOUCH = 0;
  localparam int IRQ_ON_RELEASE = 1;
  localparam logic [1:0] IRQ_MASKED = 2'h0;
  // threshold coding: code times four ticks, two zero bits appended
  localparam logic [1:0] STEP_PAD = 2'h0;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  localparam logic [3:0] COMP_SENSORS = 4'h3;
  localparam logic [7:0] STUCK_OFF = 8'h00;
  // one second of the 20 MHz reference clock
  localparam int CLK_HZ = 20_000_000;
  localparam int STUCK_UNIT_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * STUCK_UNIT_S;
endpackage : tbd_pkg

// *** src/tbd_button_decide.sv ***
// per-button touch and release decision, stuck release and compensation triggers
module tbd_button_decide (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // sample timing
  input wire logic sample_valid,
  input wire logic sec_tick,
  // sensor data
  input wire logic signed [tbd_pkg::TICK_W-1:0] ticks,
  input wire logic [7:0] threshold,
  // shared configuration
  input wire logic [7:0] hyst_pct,
  input wire logic [1:0] touch_deb,
  input wire logic [1:0] release_deb,
  input wire logic [7:0] stuck_sec,
  input wire logic [7:0] avg_code,
  input wire logic [7:0] neg_code,
  input wire logic [7:0] neg_limit,
  // decisions
  output logic touched,
  output logic touch_evt,
  output logic release_evt,
  output logic avg_suspend,
  output logic neg_trip
);
  logic [15:0] hyst_prod; // threshold times percentage
  logic [15:0] hyst_amt; // hysteresis in ticks
  logic signed [tbd_pkg::LVL_W-1:0] ticks_ext, thr_ext, hyst_ext;
  logic signed [tbd_pkg::LVL_W-1:0] upper_lvl, lower_lvl, avg_lvl, neg_lvl;
  logic above, below, neg_below; // per-sample comparisons
  logic [2:0] touch_need, release_need, deb_cnt_reg, deb_inc;
  logic [7:0] sec_cnt_reg, neg_cnt_reg;
  logic [8:0] sec_inc, neg_inc;
  logic touched_reg, hold_reg, touch_evt_reg, release_evt_reg;
  logic avg_reg, neg_trip_reg, stuck_fire;

  // levels; pct above 100 drives the release level negative, still consistent
  assign hyst_prod = threshold * hyst_pct;
  assign hyst_amt = hyst_prod / tbd_pkg::PCT_FULL;
  assign ticks_ext = tbd_pkg::LVL_W'(ticks);
  assign thr_ext = tbd_pkg::LVL_W'(threshold);
  assign hyst_ext = tbd_pkg::LVL_W'(hyst_amt);
  assign upper_lvl = thr_ext + hyst_ext;
  assign lower_lvl = thr_ext - hyst_ext;
  assign avg_lvl = tbd_pkg::LVL_W'({avg_code, tbd_pkg::STEP_PAD});
  assign neg_lvl = -tbd_pkg::LVL_W'({neg_code, tbd_pkg::STEP_PAD});
  assign above = ticks_ext > upper_lvl;
  assign below = ticks_ext < lower_lvl;
  assign neg_below = ticks_ext < neg_lvl;
  // field code 00 means one sample, i.e. decide on the incoming one
  assign touch_need = {1'b0, touch_deb} + 3'h1;
  assign release_need = {1'b0, release_deb} + 3'h1;
  assign deb_inc = deb_cnt_reg + 3'h1;
  assign sec_inc = {1'b0, sec_cnt_reg} + 9'h001;
  assign neg_inc = {1'b0, neg_cnt_reg} + 9'h001;
  // stuck timer expires on the second tick that completes the count
  assign stuck_fire = touched_reg && sec_tick && (stuck_sec != tbd_pkg::STUCK_OFF)
    && (sec_inc >= {1'b0, stuck_sec});

  // touch and release decision; stuck release wins over a same-cycle sample
  always_ff @(posedge ref_clk) begin
    touch_evt_reg <= 1'b0;
    release_evt_reg <= 1'b0;
    if (reset) begin
      touched_reg <= 1'b0;
      hold_reg <= 1'b0;
      deb_cnt_reg <= 3'h0;
    end else if (stuck_fire) begin
      // forced release; hold until the finger really lifts
      touched_reg <= 1'b0;
      release_evt_reg <= 1'b1;
      hold_reg <= 1'b1;
      deb_cnt_reg <= 3'h0;
    end else if (sample_valid) begin
      if (below) begin
        hold_reg <= 1'b0;
      end
      if (!touched_reg) begin
        // count consecutive samples above threshold plus hysteresis
        if (above && !hold_reg) begin
          if (deb_inc >= touch_need) begin
            touched_reg <= 1'b1;
            touch_evt_reg <= 1'b1;
            deb_cnt_reg <= 3'h0;
          end else begin
            deb_cnt_reg <= deb_inc;
          end
        end else begin
          deb_cnt_reg <= 3'h0;
        end
      end else begin
        // count consecutive samples below threshold minus hysteresis
        if (below) begin
          if (deb_inc >= release_need) begin
            touched_reg <= 1'b0;
            release_evt_reg <= 1'b1;
            deb_cnt_reg <= 3'h0;
          end else begin
            deb_cnt_reg <= deb_inc;
          end
        end else begin
          deb_cnt_reg <= 3'h0;
        end
      end
    end
  end

  // seconds spent touched; first second may be partial as ticks run free
  always_ff @(posedge ref_clk) begin
    if (reset || !touched_reg) begin
      sec_cnt_reg <= 8'h00;
    end else if (sec_tick) begin
      sec_cnt_reg <= sec_inc[7:0];
    end
  end

  // negative sample counter toward offset compensation
  always_ff @(posedge ref_clk) begin
    neg_trip_reg <= 1'b0;
    if (reset) begin
      neg_cnt_reg <= 8'h00;
    end else if (sample_valid) begin
      if (!neg_below) begin
        neg_cnt_reg <= 8'h00;
      end else if (neg_inc >= {1'b0, neg_limit}) begin
        neg_trip_reg <= 1'b1;
        neg_cnt_reg <= 8'h00;
      end else begin
        neg_cnt_reg <= neg_inc[7:0];
      end
    end
  end

  // averaging suspend level, refreshed each sample
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avg_reg <= 1'b0;
    end else if (sample_valid) begin
      avg_reg <= ticks_ext > avg_lvl;
    end
  end

  assign touched = touched_reg;
  assign touch_evt = touch_evt_reg;
  assign release_evt = release_evt_reg;
  assign avg_suspend = avg_reg;
  assign neg_trip = neg_trip_reg;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence stuck_expire_s;
    stuck_fire;
  endsequence
  sequence forced_release_s;
    release_evt && !touched && hold_reg ##1 !touch_evt;
  endsequence

  stuck_release_a: assert property (stuck_expire_s |=> forced_release_s)
    else $error("stuck timeout did not force a held release");
  zero_release_a: assert property (sample_valid && touched_reg && below && release_deb == 2'h0
    |=> release_evt && !touched)
    else $error("release not taken on the first low sample");
  touch_edge_a: assert property (touch_evt |-> touched && $past(!touched_reg))
    else $error("touch event without a state change");
  hold_block_a: assert property (hold_reg |-> !touch_evt)
    else $error("touch reported while stuck hold is set");
  neg_trip_a: assert property (sample_valid && neg_below && neg_inc >= {1'b0, neg_limit}
    |=> neg_trip)
    else $error("negative count limit reached without trip");
  avg_level_a: assert property (sample_valid
    |=> avg_suspend == $past(ticks_ext > avg_lvl))
    else $error("averaging suspend level wrong");
endmodule : tbd_button_decide

// *** src/tbd_button_logic.sv ***
// button decision top: registers, reporting filter, interrupt, compensation requests
// Functional notes
// - bits 7:6 select multiple or first-touch reporting
// - first-touch mode ignores others until first releases
// - bits 5:4 select touch, release, both, masked
// - bits 3:2 give release debounce of 1-4
// - bits 1:0 give touch debounce of 1-4
// - count debounce samples, one per scan period
// - touch count starts above threshold plus hysteresis
// - no debounce releases below threshold minus hysteresis
// - ticks above code times four suspend averaging
// - negative threshold is code times four ticks
// - negative count limit, default one sample
// - hysteresis is shared percentage of each threshold
// - stuck timeout in seconds, zero disables
// - stuck timeout forces release until finger lifts
// - negative counter reaching limit starts compensation
// - three sensors over averaging level start compensation
module tbd_button_logic #(
  parameter int unsigned SEC_CYCLES = tbd_pkg::SEC_CYCLES // cycles per second
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // sensing front end
  input wire logic sample_valid,
  input wire logic [tbd_pkg::NUM_BTN*tbd_pkg::TICK_W-1:0] sense_input,
  input wire logic [tbd_pkg::NUM_BTN*8-1:0] btn_threshold,
  // reported button state
  output logic [tbd_pkg::NUM_BTN-1:0] btn_status,
  output logic [tbd_pkg::NUM_BTN-1:0] touch_event,
  output logic [tbd_pkg::NUM_BTN-1:0] release_event,
  output logic btn_irq,
  // filter and compensation control
  output logic [tbd_pkg::NUM_BTN-1:0] avg_suspend,
  output logic offset_comp_req
);
  localparam int N = tbd_pkg::NUM_BTN;

  logic [7:0] cfg_reg, avg_thr_reg, neg_thr_reg, neg_cnt_reg, hyst_reg, stuck_reg;
  logic [7:0] rdata_reg; // registered read data
  logic [tbd_pkg::SEC_CNT_W-1:0] sec_div_reg; // one-second divider
  logic sec_tick; // one-cycle pulse each second
  logic [1:0] mode, irq_sel; // button_config fields
  logic [N-1:0] raw_touched, raw_touch, raw_release, raw_neg; // per-button decisions
  logic [N-1:0] rep_touch, rep_release; // events after reporting filter
  logic [N-1:0] first_touch; // lowest-index new touch
  logic [N-1:0] owner_reg; // one-hot first-touched button
  logic [N-1:0] status_reg, touch_ev_reg, release_ev_reg;
  logic irq_reg, comp_reg, avg_many_reg, avg_many;
  logic [3:0] avg_count; // sensors over averaging level

  assign mode = cfg_reg[tbd_pkg::CFG_MODE_LSB +: 2];
  assign irq_sel = cfg_reg[tbd_pkg::CFG_IRQ_LSB +: 2];

  // configuration registers, written by the host
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_reg <= tbd_pkg::CFG_RESET;
      avg_thr_reg <= tbd_pkg::AVG_RESET;
      neg_thr_reg <= tbd_pkg::NEG_THR_RESET;
      neg_cnt_reg <= tbd_pkg::NEG_CNT_RESET;
      hyst_reg <= tbd_pkg::HYST_RESET;
      stuck_reg <= tbd_pkg::STUCK_RESET;
    end else if (reg_wr_en) begin
      // writes to unmapped addresses are dropped
      unique case (reg_addr)
        tbd_pkg::ADDR_CFG: begin
          cfg_reg <= reg_wdata;
        end
        tbd_pkg::ADDR_AVG: begin
          avg_thr_reg <= reg_wdata;
        end
        tbd_pkg::ADDR_NEG_THR: begin
          neg_thr_reg <= reg_wdata;
        end
        tbd_pkg::ADDR_NEG_CNT: begin
          neg_cnt_reg <= reg_wdata;
        end
        tbd_pkg::ADDR_HYST: begin
          hyst_reg <= reg_wdata;
        end
        tbd_pkg::ADDR_STUCK: begin
          stuck_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the address; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= tbd_pkg::RDATA_NONE;
    end else begin
      unique case (reg_addr)
        tbd_pkg::ADDR_CFG: begin
          rdata_reg <= cfg_reg;
        end
        tbd_pkg::ADDR_AVG: begin
          rdata_reg <= avg_thr_reg;
        end
        tbd_pkg::ADDR_NEG_THR: begin
          rdata_reg <= neg_thr_reg;
        end
        tbd_pkg::ADDR_NEG_CNT: begin
          rdata_reg <= neg_cnt_reg;
        end
        tbd_pkg::ADDR_HYST: begin
          rdata_reg <= hyst_reg;
        end
        tbd_pkg::ADDR_STUCK: begin
          rdata_reg <= stuck_reg;
        end
        default: begin
          rdata_reg <= tbd_pkg::RDATA_NONE;
        end
      endcase
    end
  end

  // free-running one-second divider shared by all stuck timers
  always_ff @(posedge ref_clk) begin
    if (reset || sec_tick) begin
      sec_div_reg <= '0;
    end else begin
      sec_div_reg <= sec_div_reg + tbd_pkg::SEC_CNT_W'(1);
    end
  end
  assign sec_tick = sec_div_reg == tbd_pkg::SEC_CNT_W'(SEC_CYCLES - 1);

  // one decision unit per button
  generate
    for (genvar i = 0; i < N; i++) begin : g_btn
      tbd_button_decide u_decide (
        .ref_clk(ref_clk),
        .reset(reset),
        .sample_valid(sample_valid),
        .sec_tick(sec_tick),
        .ticks(sense_input[i*tbd_pkg::TICK_W +: tbd_pkg::TICK_W]),
        .threshold(btn_threshold[i*8 +: 8]),
        .hyst_pct(hyst_reg),
        .touch_deb(cfg_reg[tbd_pkg::CFG_TCH_LSB +: 2]),
        .release_deb(cfg_reg[tbd_pkg::CFG_REL_LSB +: 2]),
        .stuck_sec(stuck_reg),
        .avg_code(avg_thr_reg),
        .neg_code(neg_thr_reg),
        .neg_limit(neg_cnt_reg),
        .touched(raw_touched[i]),
        .touch_evt(raw_touch[i]),
        .release_evt(raw_release[i]),
        .avg_suspend(avg_suspend[i]),
        .neg_trip(raw_neg[i])
      );
    end
  endgenerate

  // lowest-index touch wins when several land in one sample
  assign first_touch = raw_touch & (~raw_touch + N'(1));

  // reporting filter; reserved mode codes behave as multiple reporting
  always_comb begin
    rep_touch = raw_touch;
    rep_release = raw_release;
    if (mode == tbd_pkg::MODE_FIRST) begin
      if (|owner_reg) begin
        // others ignored until the owner releases
        rep_touch = '0;
        rep_release = raw_release & owner_reg;
      end else begin
        rep_touch = first_touch;
        rep_release = '0;
      end
    end
  end

  // owner of first-touch reporting
  always_ff @(posedge ref_clk) begin
    if (reset || mode != tbd_pkg::MODE_FIRST) begin
      owner_reg <= '0;
    end else if (|(rep_release & owner_reg)) begin
      owner_reg <= '0;
    end else if (|rep_touch) begin
      owner_reg <= rep_touch;
    end
  end

  // reported status and event pulses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= '0;
      touch_ev_reg <= '0;
      release_ev_reg <= '0;
    end else begin
      status_reg <= (status_reg | rep_touch) & ~rep_release;
      touch_ev_reg <= rep_touch;
      release_ev_reg <= rep_release;
    end
  end

  // interrupt pulse on events matching the selected source
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (|rep_touch && irq_sel[tbd_pkg::IRQ_ON_TOUCH])
        || (|rep_release && irq_sel[tbd_pkg::IRQ_ON_RELEASE]);
    end
  end

  // count sensors over the averaging level
  always_comb begin
    avg_count = 4'h0;
    for (int k = 0; k < N; k++) begin
      avg_count = avg_count + 4'(avg_suspend[k]);
    end
  end
  assign avg_many = avg_count >= tbd_pkg::COMP_SENSORS;

  // compensation request; fires once as the group crosses, not every cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avg_many_reg <= 1'b0;
      comp_reg <= 1'b0;
    end else begin
      avg_many_reg <= avg_many;
      comp_reg <= (|raw_neg) || (avg_many && !avg_many_reg);
    end
  end

  assign reg_rdata = rdata_reg;
  assign btn_status = status_reg;
  assign touch_event = touch_ev_reg;
  assign release_event = release_ev_reg;
  assign btn_irq = irq_reg;
  assign offset_comp_req = comp_reg;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (reset);

  cfg_default_a: assert property ($fell(reset) |-> cfg_reg == tbd_pkg::CFG_RESET)
    else $error("button_config not at default after reset");
  first_only_a: assert property (mode == tbd_pkg::MODE_FIRST && |owner_reg
    |=> touch_event == '0)
    else $error("second touch reported in first-touch mode");
  irq_masked_a: assert property (irq_sel == tbd_pkg::IRQ_MASKED |=> !btn_irq)
    else $error("interrupt while masked");
  irq_touch_a: assert property (|rep_touch && irq_sel[tbd_pkg::IRQ_ON_TOUCH]
    |=> btn_irq && touch_event != '0)
    else $error("touch interrupt missing");
  irq_cause_a: assert property (btn_irq |-> (touch_event != '0 || release_event != '0))
    else $error("interrupt without a reported event");
  comp_three_a: assert property (avg_many && !avg_many_reg |=> offset_comp_req)
    else $error("three-sensor compensation not requested");
  comp_neg_a: assert property (|raw_neg |=> offset_comp_req)
    else $error("negative compensation not requested");
  status_track_a: assert property (|touch_event |-> |btn_status)
    else $error("status does not show reported touch");
endmodule : tbd_button_logic

// *** test/tbd_front_end_model.sv ***
// behavioural capacitive front end that hands tick samples to the decision logic
module tbd_front_end_model (
  // sample request and tick values from the bench
  input wire logic load,
  input wire logic [tbd_pkg::NUM_BTN*tbd_pkg::TICK_W-1:0] ticks,
  // sample bus towards the decision logic
  output logic sample_valid,
  output logic [tbd_pkg::NUM_BTN*tbd_pkg::TICK_W-1:0] sense_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // the strobe is the request itself, high for as long as the request is held
  assign sample_valid = load;
  // outside the strobe the ticks are stale, so show the inverse:
  // a design that reads them off-strobe then decides wrongly and gets caught
  assign sense_input = load ? ticks : ~ticks;
endmodule : tbd_front_end_model

// *** test/testbench.sv ***
// self-checking bench with a reference model of the button decision logic
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NB = tbd_pkg::NUM_BTN; // buttons
  localparam int SECS = 20; // shortened second keeps the stuck test short
  localparam logic [7:0] RST_TAB [7] = '{8'h30, 8'h50, 8'h50, 8'h01, 8'h0a, 8'h00, 8'h00};
  // design stimulus, all given a value at time zero
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic load = 1'b0;
  logic [NB*16-1:0] ticks_flat = '0;
  logic [NB*8-1:0] btn_threshold = '0;
  // design outputs
  logic [7:0] reg_rdata;
  logic sample_valid;
  logic [NB*16-1:0] sense_input;
  logic [NB-1:0] btn_status, touch_event, release_event, avg_suspend;
  logic btn_irq, offset_comp_req;
  // counters and random state
  int errors = 0;
  int compares = 0;
  logic [31:0] seed = 32'd90570;
  // reference model state
  int thr[NB], tk[NB], tc[NB], rc[NB], nc[NB];
  bit raw[NB], st[NB], lock[NB];
  int owner = -1;
  int prev_sus = 0;
  logic [7:0] cfg = tbd_pkg::CFG_RESET;
  int avg = 32'h50, nthr = 32'h50, nlim = 1, hyst = 32'h0a;

  tbd_button_logic #(.SEC_CYCLES(SECS)) tbd_button_logic_i (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sense_input(sense_input), .btn_threshold(btn_threshold), .btn_status(btn_status),
    .touch_event(touch_event), .release_event(release_event), .btn_irq(btn_irq),
    .avg_suspend(avg_suspend), .offset_comp_req(offset_comp_req));

  tbd_front_end_model tbd_front_end_model_i (
    .load(load), .ticks(ticks_flat), .sample_valid(sample_valid), .sense_input(sense_input));

  // free running clock
  always #25 ref_clk = ~ref_clk;

  // xorshift source for random stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // tick level of a kind: 0 above upper, 1 below lower, 2 below negative, 3 on a boundary with zero debounce, else above upper
  function automatic int level(int i, int kind);
    int d;
    d = thr[i] * hyst / 100;
    case (kind)
      0: return thr[i] + d + 1;
      1: return thr[i] - d - 1;
      2: return -(nthr * 4) - 1;
      default: return (cfg[3:0] != 4'h0) ? thr[i] + d + 1 : (raw[i] ? thr[i] - d : thr[i] + d);
    endcase
  endfunction : level

  // one comparison, counted
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // register read, answer one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    @(negedge ref_clk);
    chk(reg_rdata, exp, "register read");
  endtask : rd

  // register write, then read back; unmapped places read zero
  task automatic setreg(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, (a >= 8'h21 && a <= 8'h26) ? d : 8'h00, "register readback");
    case (a)
      tbd_pkg::ADDR_CFG: cfg = d;
      tbd_pkg::ADDR_AVG: avg = int'(d);
      tbd_pkg::ADDR_NEG_THR: nthr = int'(d);
      tbd_pkg::ADDR_NEG_CNT: nlim = int'(d);
      tbd_pkg::ADDR_HYST: hyst = int'(d);
      default: ;
    endcase
  endtask : setreg

  // one scan sample: model step, drive, compare two edges later
  task automatic sample();
    int up, lo, sus, ev, own;
    logic [7:0] et, er, es, ea;
    bit trip;
    sus = 0;
    trip = 0;
    et = '0;
    er = '0;
    ea = '0;
    own = owner; // owner as it stood before this sample
    for (int i = 0; i < NB; i++) begin
      up = thr[i] + thr[i] * hyst / 100;
      lo = thr[i] - thr[i] * hyst / 100;
      ev = 0;
      ticks_flat[16*i +: 16] = 16'(tk[i]);
      btn_threshold[8*i +: 8] = 8'(thr[i]);
      if (tk[i] > avg * 4) begin
        ea[i] = 1'b1;
        sus++;
      end
      if (tk[i] < -(nthr * 4)) begin
        nc[i]++;
        if (nc[i] >= ((nlim == 0) ? 1 : nlim)) begin
          trip = 1;
          nc[i] = 0;
        end
      end else
        nc[i] = 0;
      if (!raw[i]) begin
        if (lock[i])
          lock[i] = !(tk[i] < lo);
        else if (tk[i] > up) begin
          tc[i]++;
          if (tc[i] > int'(cfg[1:0])) begin
            raw[i] = 1;
            tc[i] = 0;
            ev = 1;
          end
        end else
          tc[i] = 0;
      end else if (tk[i] < lo) begin
        rc[i]++;
        if (rc[i] > int'(cfg[3:2])) begin
          raw[i] = 0;
          rc[i] = 0;
          ev = 2;
        end
      end else
        rc[i] = 0;
      if (cfg[7:6] == 2'b01 && (own >= 0 ? own != i : (ev == 2 || owner >= 0)))
        ev = 0;
      if (ev == 1) begin
        et[i] = 1'b1;
        st[i] = 1;
        if (cfg[7:6] == 2'b01)
          owner = i;
      end
      if (ev == 2) begin
        er[i] = 1'b1;
        st[i] = 0;
        if (owner == i)
          owner = -1;
      end
      es[i] = st[i];
    end
    if (cfg[7:6] != 2'b01)
      owner = -1;
    trip = trip | (sus >= 3 && prev_sus < 3);
    prev_sus = sus;
    load = 1'b1;
    @(negedge ref_clk);
    load = 1'b0;
    @(negedge ref_clk); // event pulses stand only until the third edge
    chk(touch_event, et, "touch event");
    chk(release_event, er, "release event");
    chk(btn_status, es, "button status");
    chk({7'h0, btn_irq}, {7'h0, (|et & cfg[4]) | (|er & cfg[5])}, "interrupt");
    chk(avg_suspend, ea, "averaging suspend");
    chk({7'h0, offset_comp_req}, {7'h0, trip}, "compensation");
  endtask : sample

  // bring every button to rest under the current settings
  task automatic settle();
    for (int i = 0; i < NB; i++)
      tk[i] = 0;
    repeat (4) sample();
  endtask : settle

  // hang guard
  initial begin
    #2_000_000;
    errors++;
    $display("MISMATCH %0t run did not finish in time", $time);
    complete_run();
  end

  initial begin
    int v;
    int n;
    for (int i = 0; i < NB; i++)
      thr[i] = 100;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    for (int a = 0; a < 7; a++)
      rd(8'h21 + 8'(a), RST_TAB[a]);
    setreg(8'h27, 8'h5a);
    // random rounds: codes, debounce, levels, interrupt field, thresholds
    for (int r = 0; r < 8; r++) begin
      settle();
      v = rnd();
      setreg(tbd_pkg::ADDR_CFG, {(r == 7) ? 2'b10 : 2'b00, v[5:4], 4'(r * 5)});
      setreg(tbd_pkg::ADDR_AVG, 8'h10 + {2'h0, v[13:8]});
      setreg(tbd_pkg::ADDR_NEG_THR, {4'h0, v[19:16]} + 8'h01);
      setreg(tbd_pkg::ADDR_NEG_CNT, {6'h0, v[21:20]});
      setreg(tbd_pkg::ADDR_HYST, 8'(v[30:24] % 91));
      for (int i = 0; i < NB; i++)
        thr[i] = 40 + int'(rnd() % 160);
      repeat (14) begin
        for (int i = 0; i < NB; i++)
          tk[i] = level(i, int'(rnd() % 4));
        sample();
      end
    end
    // first-touch reporting: simultaneous touch, lowest index owns
    settle();
    setreg(tbd_pkg::ADDR_CFG, 8'h70);
    tk[0] = level(0, 0);
    tk[1] = level(1, 0);
    sample();
    tk[1] = 0;
    sample();
    tk[0] = 0;
    sample();
    tk[1] = level(1, 0);
    sample();
    settle();
    // stuck timeout forces a release and blocks the held finger
    setreg(tbd_pkg::ADDR_CFG, 8'h30);
    setreg(tbd_pkg::ADDR_STUCK, 8'h01);
    tk[2] = level(2, 0);
    sample();
    n = 0;
    repeat (2 * SECS + 5) begin
      @(negedge ref_clk);
      if (release_event[2] === 1'b1)
        n++;
    end
    chk(8'(n), 8'h01, "forced release count");
    raw[2] = 0;
    st[2] = 0;
    lock[2] = 1;
    rc[2] = 0;
    chk(btn_status, 8'h00, "status after forced release");
    sample();
    tk[2] = 0;
    sample();
    setreg(tbd_pkg::ADDR_STUCK, 8'h00);
    tk[2] = level(2, 0);
    sample();
    settle();
    // second reset in mid-run must reload every default
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    chk(btn_status, 8'h00, "status after reset");
    for (int a = 0; a < 7; a++)
      rd(8'h21 + 8'(a), RST_TAB[a]);
    complete_run();
  end
endmodule : testbench
